// file: rtl/sacr_top.sv
// APB register bank for the auxiliary fraction and loop configuration of the synthesizer.
//
// Function
// - Select 0010 loads modulus from bits 17:4
// - Select 0011 loads the auxiliary fraction
// - Fraction is a 14-bit word
// - Modulus and fraction apply on register 0
// - Select 0100 loads the configuration
// - Bit 30 enables second-stage dither
// - Bits 29:27 pick the monitor source
// - Bit 26 selects the doubled reference
// - Doubler picks falling or both edges
// - Bit 25 adds a half divider
// - Ten-bit reference ratio, host uses 1..1023
// - Bit 14 buffers the divider select
// - Buffered divider select applies on register 0
// - Bits 13:10 set pump current
// - Bit 8 sets monitor high level
// - Bit 7 sets detector polarity
module sacr_top
    import sacr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reference_input,
    output sacr_cfg_s loop_cfg,
    output sacr_aux_s aux_active,
    output logic [2:0] out_div_sel,
    output logic pfd_ref,
    output logic pfd_active_edge
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave state.
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic take;
    logic addr_ok;
    logic bad_access;
    logic wr_word;

    // Register state.
    sacr_aux_s aux_stage_q;
    sacr_aux_s aux_stage_d;
    sacr_aux_s aux_act_q;
    sacr_aux_s aux_act_d;
    sacr_cfg_s cfg_q;
    sacr_cfg_s cfg_d;
    logic aux_pend_q;
    logic aux_pend_d;
    logic [2:0] odiv_stage_q;
    logic [2:0] odiv_stage_d;
    logic [2:0] odiv_act_q;
    logic [2:0] odiv_act_d;
    logic odiv_pend_q;
    logic odiv_pend_d;
    logic [3:0] last_sel_q;
    logic [3:0] last_sel_d;
    logic ref_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: every access phase takes two cycles, the first to build the
    // answer, the second to present it. This keeps all bus outputs on flops.
    always_comb
    begin
        addr_ok = (paddr == ADDR_WORD_PORT) || (paddr == ADDR_STATUS);
        // Partial-word writes are refused because a word must arrive whole.
        bad_access = !addr_ok
            || (pwrite && (paddr == ADDR_STATUS))
            || (pwrite && (pstrb != STRB_FULL));
        take = psel && penable && pready_q;
        wr_word = take && pwrite && !pslverr_q && (paddr == ADDR_WORD_PORT);
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (psel && penable && !pready_q)
        begin
            pready_d = 1'b1;
            pslverr_d = bad_access;
            // Write-only fields
            // Only the status word reads back; the word port reads as zero.
            if (!pwrite && (paddr == ADDR_STATUS))
            begin
                prdata_d = {24'h00_0000, last_sel_q, 2'b00, odiv_pend_q, aux_pend_q};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word routing by select code.
    always_comb
    begin
        aux_stage_d = aux_stage_q;
        aux_act_d = aux_act_q;
        cfg_d = cfg_q;
        aux_pend_d = aux_pend_q;
        odiv_stage_d = odiv_stage_q;
        odiv_act_d = odiv_act_q;
        odiv_pend_d = odiv_pend_q;
        last_sel_d = last_sel_q;
        if (wr_word)
        begin
            last_sel_d = pwdata[SEL_MSB:SEL_LSB];
            // Reserved bits dropped
            // Only the documented field bits are copied; the rest of the word is unused.
            if (sel_is(pwdata, SEL_AUX_MOD))
            begin
                aux_stage_d.modulus = pwdata[AUX_MSB:AUX_LSB];
                aux_pend_d = 1'b1;
            end
            else if (sel_is(pwdata, SEL_AUX_FRAC))
            begin
                // Fraction below modulus
                // The ordering of fraction and modulus is left to software; no check here.
                aux_stage_d.fraction = pwdata[AUX_MSB:AUX_LSB];
                aux_pend_d = 1'b1;
            end
            else if (sel_is(pwdata, SEL_LOOP_CFG))
            begin
                cfg_d.dither_en = pwdata[DITHER_BIT];
                cfg_d.monitor_sel = pwdata[MON_SEL_MSB:MON_SEL_LSB];
                cfg_d.doubler_en = pwdata[DOUBLER_BIT];
                cfg_d.half_div_en = pwdata[HALF_DIV_BIT];
                cfg_d.r_count = pwdata[RCNT_MSB:RCNT_LSB];
                cfg_d.buf_en = pwdata[BUF_EN_BIT];
                cfg_d.cp_current = pwdata[CP_MSB:CP_LSB];
                cfg_d.monitor_level = pwdata[MON_LEVEL_BIT];
                cfg_d.pd_polarity = pwdata[PD_POL_BIT];
            end
            else if (sel_is(pwdata, SEL_OUT_DIV))
            begin
                if (cfg_q.buf_en)
                begin
                    odiv_stage_d = pwdata[ODIV_MSB:ODIV_LSB];
                    odiv_pend_d = 1'b1;
                end
                else
                begin
                    odiv_act_d = pwdata[ODIV_MSB:ODIV_LSB];
                end
            end
            else if (sel_is(pwdata, SEL_FREQ_INT))
            begin
                aux_act_d = aux_stage_q;
                aux_pend_d = 1'b0;
                // Apply buffered divider select
                // A pending select is dropped if buffering was turned off meanwhile.
                if (odiv_pend_q && cfg_q.buf_en)
                begin
                    odiv_act_d = odiv_stage_q;
                end
                odiv_pend_d = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            aux_stage_q <= RST_AUX_S;
            aux_act_q <= RST_AUX_S;
            cfg_q <= RST_CFG_S;
            aux_pend_q <= 1'b0;
            odiv_stage_q <= RST_ODIV;
            odiv_act_q <= RST_ODIV;
            odiv_pend_q <= 1'b0;
            last_sel_q <= SEL_FREQ_INT;
        end
        else
        begin
            aux_stage_q <= aux_stage_d;
            aux_act_q <= aux_act_d;
            cfg_q <= cfg_d;
            aux_pend_q <= aux_pend_d;
            odiv_stage_q <= odiv_stage_d;
            odiv_act_q <= odiv_act_d;
            odiv_pend_q <= odiv_pend_d;
            last_sel_q <= last_sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference path toward the phase detector.
    sacr_ref_edge u_ref_edge (
        .pclk(pclk),
        .presetn(presetn),
        .reference_input(reference_input),
        .doubler_en(cfg_q.doubler_en),
        .ref_tick(ref_tick)
    );

    sacr_ref_div u_ref_div (
        .pclk(pclk),
        .presetn(presetn),
        .ref_tick(ref_tick),
        .r_count(cfg_q.r_count),
        .half_div_en(cfg_q.half_div_en),
        .pfd_ref(pfd_ref),
        .pfd_edge(pfd_active_edge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign loop_cfg = cfg_q;
    assign aux_active = aux_act_q;
    assign out_div_sel = odiv_act_q;

endmodule // sacr_top

// file: rtl/sacr_pkg.sv
// Shared constants, field layouts and carrier types of the synthesizer control registers.
package sacr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register select codes held in the four low bits of each written word.
    localparam logic [3:0] SEL_FREQ_INT = 4'h0;
    localparam logic [3:0] SEL_AUX_MOD = 4'h2;
    localparam logic [3:0] SEL_AUX_FRAC = 4'h3;
    localparam logic [3:0] SEL_LOOP_CFG = 4'h4;
    localparam logic [3:0] SEL_OUT_DIV = 4'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions inside a written word.
    localparam int SEL_MSB = 3;
    localparam int SEL_LSB = 0;
    localparam int AUX_MSB = 17;
    localparam int AUX_LSB = 4;
    localparam int DITHER_BIT = 30;
    localparam int MON_SEL_MSB = 29;
    localparam int MON_SEL_LSB = 27;
    localparam int DOUBLER_BIT = 26;
    localparam int HALF_DIV_BIT = 25;
    localparam int RCNT_MSB = 24;
    localparam int RCNT_LSB = 15;
    localparam int BUF_EN_BIT = 14;
    localparam int CP_MSB = 13;
    localparam int CP_LSB = 10;
    localparam int MON_LEVEL_BIT = 8;
    localparam int PD_POL_BIT = 7;
    localparam int ODIV_MSB = 23;
    localparam int ODIV_LSB = 21;

    ////////////////////////////////////////////////////////////////////////////
    // Bus map: byte addresses of the word port and the status register.
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_WORD_PORT = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
    localparam logic [3:0] STRB_FULL = 4'hf;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [13:0] RST_AUX = 14'h0000;
    localparam logic [9:0] RST_RCNT = 10'h001;
    localparam logic [3:0] RST_CP = 4'h0;
    localparam logic [2:0] RST_MON_SEL = 3'h0;
    localparam logic [2:0] RST_ODIV = 3'h0;
    localparam logic [9:0] RCNT_ONE = 10'h001;

    ////////////////////////////////////////////////////////////////////////////
    // Carrier types.
    typedef struct packed {
        logic [13:0] modulus;
        logic [13:0] fraction;
    } sacr_aux_s;

    typedef struct packed {
        logic dither_en;
        logic [2:0] monitor_sel;
        logic doubler_en;
        logic half_div_en;
        logic [9:0] r_count;
        logic buf_en;
        logic [3:0] cp_current;
        logic monitor_level;
        logic pd_polarity;
    } sacr_cfg_s;

    localparam sacr_aux_s RST_AUX_S = '{modulus: RST_AUX, fraction: RST_AUX};
    localparam sacr_cfg_s RST_CFG_S = '{
        dither_en: 1'b0, monitor_sel: RST_MON_SEL, doubler_en: 1'b0, half_div_en: 1'b0,
        r_count: RST_RCNT, buf_en: 1'b0, cp_current: RST_CP, monitor_level: 1'b0,
        pd_polarity: 1'b0};

    // True when the word carries the given register select code.
    function automatic logic sel_is(input logic [31:0] word, input logic [3:0] code);
        sel_is = (word[SEL_MSB:SEL_LSB] == code);
    endfunction

endpackage

// file: rtl/sacr_ref_edge.sv
// Reference edge picker: chooses which reference edges clock the reference counter.
module sacr_ref_edge
    import sacr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic reference_input,
    input wire logic doubler_en,
    output logic ref_tick
);

    logic ref_prev_q;
    logic ref_prev_d;
    logic ref_tick_q;
    logic ref_tick_d;

    always_comb
    begin
        ref_prev_d = reference_input;
        if (doubler_en)
        begin
            ref_tick_d = reference_input ^ ref_prev_q;
        end
        else
        begin
            ref_tick_d = ref_prev_q & ~reference_input;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_prev_q <= 1'b0;
            ref_tick_q <= 1'b0;
        end
        else
        begin
            ref_prev_q <= ref_prev_d;
            ref_tick_q <= ref_tick_d;
        end
    end

    assign ref_tick = ref_tick_q;

endmodule // sacr_ref_edge

// file: rtl/sacr_ref_div.sv
// Reference counter with optional divide-by-two toggle stage toward the phase detector.
module sacr_ref_div
    import sacr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ref_tick,
    input wire logic [9:0] r_count,
    input wire logic half_div_en,
    output logic pfd_ref,
    output logic pfd_edge
);

    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic toggle_q;
    logic toggle_d;
    logic pfd_ref_q;
    logic pfd_ref_d;
    logic pfd_edge_q;
    logic pfd_edge_d;
    logic terminal;

    always_comb
    begin
        cnt_d = cnt_q;
        toggle_d = toggle_q;
        pfd_edge_d = 1'b0;
        // Divide by ratio
        // A ratio of zero is outside the legal range and behaves as a ratio of one.
        terminal = ref_tick && ((cnt_q + RCNT_ONE) >= r_count);
        if (ref_tick)
        begin
            cnt_d = terminal ? 10'h000 : cnt_q + RCNT_ONE;
        end
        if (terminal)
        begin
            toggle_d = ~toggle_q;
            pfd_edge_d = half_div_en ? ~toggle_q : 1'b1;
        end
        pfd_ref_d = half_div_en ? toggle_d : terminal;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 10'h000;
            toggle_q <= 1'b0;
            pfd_ref_q <= 1'b0;
            pfd_edge_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            toggle_q <= toggle_d;
            pfd_ref_q <= pfd_ref_d;
            pfd_edge_q <= pfd_edge_d;
        end
    end

    assign pfd_ref = pfd_ref_q;
    assign pfd_edge = pfd_edge_q;

endmodule // sacr_ref_div

// file: verification/sacr_top_chk.sv
// Concurrent checks on the ports of the synthesizer register bank.
module sacr_top_chk
    import sacr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reference_input,
    input wire sacr_cfg_s loop_cfg,
    input wire sacr_aux_s aux_active,
    input wire logic [2:0] out_div_sel,
    input wire logic pfd_ref,
    input wire logic pfd_active_edge
);
    timeunit 1ns;
    timeprecision 1ps;
    logic done;
    logic [3:0] code;
    logic one_ref;
    sacr_aux_s stage_q;
    sacr_aux_s stage_d;
    assign done = psel && penable && pready && pwrite && paddr == ADDR_WORD_PORT
        && pstrb == STRB_FULL && !pslverr;
    assign code = pwdata[3:0];
    assign one_ref = !loop_cfg.half_div_en && loop_cfg.r_count == RCNT_ONE;
    ////////////////////////////////////////////////////////////////////////////
    // A shadow of the staged pair lets the apply step be judged without the design's state.
    always_comb
    begin
        stage_d = stage_q;
        if (done && code == SEL_AUX_MOD)
            stage_d.modulus = pwdata[AUX_MSB:AUX_LSB];
        if (done && code == SEL_AUX_FRAC)
            stage_d.fraction = pwdata[AUX_MSB:AUX_LSB];
    end
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            stage_q <= RST_AUX_S;
        else
            stage_q <= stage_d;
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_cfg;
        done && code == SEL_LOOP_CFG;
    endsequence
    sequence s_apply;
        done && code == SEL_FREQ_INT;
    endsequence
    sequence s_applied;
        ##1 aux_active == stage_q;
    endsequence
    a_dither_load:
        assert property (s_cfg |=> loop_cfg.dither_en == $past(pwdata[DITHER_BIT]))
        else $error("dither bit not loaded");
    a_ref_fields:
        assert property (s_cfg |=> {loop_cfg.monitor_sel, loop_cfg.doubler_en,
            loop_cfg.half_div_en, loop_cfg.r_count} == $past(pwdata[29:15]))
        else $error("monitor or reference fields not loaded");
    a_pump_fields:
        assert property (s_cfg |=> {loop_cfg.buf_en, loop_cfg.cp_current} == $past(pwdata[14:10])
            && {loop_cfg.monitor_level, loop_cfg.pd_polarity} == $past(pwdata[8:7]))
        else $error("pump, level or polarity not loaded");
    a_cfg_hold:
        assert property (!(done && code == SEL_LOOP_CFG) |=> $stable(loop_cfg))
        else $error("configuration changed without its word");
    a_aux_apply:
        assert property (s_apply |-> s_applied)
        else $error("staged pair not applied");
    a_aux_hold:
        assert property (!(done && code == SEL_FREQ_INT) |=> $stable(aux_active))
        else $error("aux pair changed without apply");
    a_odiv_direct:
        assert property (done && code == SEL_OUT_DIV && !loop_cfg.buf_en
            |=> out_div_sel == $past(pwdata[ODIV_MSB:ODIV_LSB]))
        else $error("divider select not immediate");
    a_odiv_held:
        assert property (done && code == SEL_OUT_DIV && loop_cfg.buf_en |=> $stable(out_div_sel))
        else $error("buffered divider select leaked");
    a_fall_edge:
        assert property ($fell(reference_input) && !loop_cfg.doubler_en && one_ref
            |-> ##[1:4] pfd_active_edge)
        else $error("falling edge gave no detector edge");
    // The half-divider setting is taken one cycle late because the detector outputs are flopped.
    a_ref_track:
        assert property (!$past(loop_cfg.half_div_en) |-> pfd_ref == pfd_active_edge)
        else $error("detector reference differs from its edge pulse");
    a_ref_level:
        assert property (pfd_active_edge |-> pfd_ref)
        else $error("detector edge without a high reference");
endmodule // sacr_top_chk

bind sacr_top sacr_top_chk u_sacr_top_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pslverr, .reference_input, .loop_cfg, .aux_active, .out_div_sel,
    .pfd_ref, .pfd_active_edge);

// file: verification/sacr_host_model.sv
// APB host model that plays the controller sending configuration words.
module sacr_host_model
    import sacr_pkg::*;
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    // Released address and data are inverted so that a stale value is never mistaken for valid.
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // sacr_host_model

// file: verification/test_synth_aux_fraction_config_regs.sv
// Self-checking bench for the synthesizer register bank.
module test_synth_aux_fraction_config_regs
    import sacr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic reference_input = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [3:0] pstrb;
    sacr_cfg_s loop_cfg;
    sacr_aux_s aux_active;
    logic [2:0] out_div_sel;
    logic pfd_active_edge;
    int n_fail = 0;
    int checks_done = 0;
    int n_edges = 0;
    logic [31:0] cws [2] = '{32'h5a5aa5a4, 32'ha5a55a54};
    always #2 pclk = ~pclk;
    always @(posedge pclk)
        if (pfd_active_edge === 1'b1)
            n_edges <= n_edges + 1;
    sacr_top u_sacr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .reference_input, .loop_cfg, .aux_active, .out_div_sel,
        .pfd_ref(), .pfd_active_edge);
    sacr_host_model u_sacr_host_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [31:0] exp, input logic ee);
        logic [31:0] r;
        logic e;
        u_sacr_host_model.xfer(w, a, d, s, r, e);
        if (!w)
            chk(r, exp);
        chk({31'h0, e}, {31'h0, ee});
        @(posedge pclk);
    endtask
    task automatic wr(input logic [31:0] d);
        xfer(1'b1, ADDR_WORD_PORT, d, STRB_FULL, 32'h0, 1'b0);
    endtask
    // Loop word with only the reference path and buffer enable set.
    function automatic logic [31:0] cw(input logic dbl, input logic half, input logic [9:0] rc,
        input logic bf);
        return {5'h0, dbl, half, rc, bf, 10'h0, SEL_LOOP_CFG};
    endfunction
    function automatic sacr_cfg_s cx(input logic [31:0] w);
        return {w[30:15], w[14:10], w[8:7]};
    endfunction
    task automatic refrun(input int n, input int exp);
        n_edges = 0;
        repeat (n)
        begin
            repeat (4) @(posedge pclk);
            reference_input <= ~reference_input;
        end
        repeat (8) @(posedge pclk);
        chk(n_edges, exp);
    endtask
    task automatic results();
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_fail++;
        results();
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(loop_cfg), 32'(RST_CFG_S));
        chk(32'(aux_active), 32'h0);
        // Boundary values; the fraction stays below the modulus, reserved bits zero.
        wr(32'h0003fff2);
        wr(32'h0003ffe3);
        chk(32'(aux_active), 32'h0);
        xfer(1'b0, ADDR_STATUS, 32'h0, STRB_FULL, 32'h31, 1'b0);
        wr(32'h0);
        chk(32'(aux_active), {4'h0, 14'h3fff, 14'h3ffe});
        xfer(1'b0, ADDR_STATUS, 32'h0, STRB_FULL, 32'h0, 1'b0);
        xfer(1'b0, ADDR_WORD_PORT, 32'h0, STRB_FULL, 32'h0, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            wr(cws[i]);
            chk(32'(loop_cfg), 32'(cx(cws[i])));
        end
        xfer(1'b1, ADDR_STATUS, cws[0], STRB_FULL, 32'h0, 1'b1);
        xfer(1'b1, 12'h008, cws[0], STRB_FULL, 32'h0, 1'b1);
        xfer(1'b1, ADDR_WORD_PORT, cws[0], 4'h3, 32'h0, 1'b1);
        chk(32'(loop_cfg), 32'(cx(cws[1])));
        wr(cw(1'b0, 1'b0, 10'h001, 1'b0));
        wr(32'h00a00006);
        chk(32'(out_div_sel), 32'h5);
        wr(cw(1'b0, 1'b0, 10'h001, 1'b1));
        wr(32'h00600006);
        chk(32'(out_div_sel), 32'h5);
        xfer(1'b0, ADDR_STATUS, 32'h0, STRB_FULL, 32'h62, 1'b0);
        wr(32'h0);
        chk(32'(out_div_sel), 32'h3);
        refrun(16, 8);
        wr(cw(1'b1, 1'b0, 10'h001, 1'b0));
        refrun(16, 16);
        wr(cw(1'b1, 1'b1, 10'h002, 1'b0));
        refrun(16, 4);
        results();
    end
endmodule // test_synth_aux_fraction_config_regs
